// ### rtl/clock_reset_consts.svh
// timing constants and reset values for the clock/reset startup monitor
`ifndef CLOCK_RESET_CONSTS_SVH
`define CLOCK_RESET_CONSTS_SVH

`define CLK_PERIOD_PS        32'd4000
// crystal monitor stall window, in ns
`define XMON_MIN_NS          32'd6000
`define XMON_MAX_NS          32'd18500
// stall count: least time rounded up, must stay below the longest time
`define XMON_CYCLES          ((`XMON_MIN_NS * 32'd1000 + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define XMON_MAX_CYCLES      ((`XMON_MAX_NS * 32'd1000) / `CLK_PERIOD_PS)
// quality check windows, in us (longest times round down)
`define CHECK_WINDOW_US      32'd20000
`define TIMEOUT_WINDOW_US    32'd1000000
`define CHECK_WINDOW_CYCLES  ((`CHECK_WINDOW_US * 32'd1000) / (`CLK_PERIOD_PS / 32'd1000))
`define TIMEOUT_CYCLES       ((`TIMEOUT_WINDOW_US * 32'd1000) / (`CLK_PERIOD_PS / 32'd1000))
// good oscillator edges needed inside one check window
`define CHECK_EDGES          16'd4096
// reset pulse and startup, in oscillator periods
`define MIN_RESET_PULSE_OSC  8'd2
`define STARTUP_OSC_CYCLES   8'd192
`define STARTUP_OSC_MAX      8'd196
// wait recovery, in system clock cycles
`define WAIT_RECOVERY_CYC    8'd14

`endif

// ### rtl/clock_reset_pkg.sv
// types shared by the clock/reset startup monitor
package clock_reset_pkg;
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_STOP,
      MODE_PSEUDO_STOP,
      MODE_DOZE
   } low_power_mode_type;

   // clock status seen by the rest of the chip
   typedef struct packed {
      logic osc_enable;
      logic sys_clk_enable;
      logic self_clock_mode;
      logic use_vco_source;
   } clock_status_type;

   // wakeup request bundle
   typedef struct packed {
      logic ext_irq;
      logic int_irq;
      logic other_event;
   } wakeup_type;

   // clock/reset flag register contents
   typedef struct packed {
      logic power_on_reset_flag;
      logic low_voltage_reset_flag;
      logic stable_osc_seen;
      logic self_clock_active;
   } clock_reset_flag_register_type;
endpackage

// ### rtl/crystal_monitor.sv
// crystal monitor: flags an oscillator clock stalled high or low
`timescale 1ns/10ps
`default_nettype none
`include "clock_reset_consts.svh"
module crystal_monitor (
   input  wire logic core_clk_i,
   input  wire logic resetn_i,
   input  wire logic enable_i,
   input  wire logic osc_level_i,
   output logic      osc_edge_o,
   output logic      osc_fail_o
);
   localparam logic [15:0] STALL_LIMIT = 16'(`XMON_CYCLES);

   logic        osc_level_r;
   logic [15:0] stall_cnt_r;
   logic [15:0] stall_cnt_nxt;
   logic        osc_fail_r;

   // an edge is any change of the sampled oscillator level
   assign osc_edge_o    = enable_i && (osc_level_i != osc_level_r);
   assign stall_cnt_nxt = (!enable_i || osc_edge_o) ? 16'h0000 :
                          (stall_cnt_r == STALL_LIMIT) ? stall_cnt_r : stall_cnt_r + 16'h0001;

   // stall counter restarts on either edge, so high and low stalls count alike
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         osc_level_r <= 1'b0;
         stall_cnt_r <= 16'h0000;
         osc_fail_r  <= 1'b0;
      end else begin
         osc_level_r <= osc_level_i;
         stall_cnt_r <= stall_cnt_nxt;
         osc_fail_r  <= enable_i && (stall_cnt_nxt == STALL_LIMIT);
      end
   end
   assign osc_fail_o = osc_fail_r;

   property p_fail_after_stall;
      @(posedge core_clk_i) disable iff (!resetn_i)
      $rose(osc_fail_r) |-> $past(stall_cnt_r) == STALL_LIMIT - 16'h0001;
   endproperty
   a_fail_after_stall: assert property (p_fail_after_stall)
      else $error("crystal monitor fired before the least stall time");

   property p_no_fail_on_edge;
      @(posedge core_clk_i) disable iff (!resetn_i)
      osc_edge_o |=> !osc_fail_r;
   endproperty
   a_no_fail_on_edge: assert property (p_no_fail_on_edge)
      else $error("crystal monitor flagged failure despite an oscillator edge");
endmodule
`default_nettype wire

// ### rtl/clock_reset_startup_monitor.sv
// clock and reset startup, supervision and low-power recovery sequencer
// Functional notes
// - flag oscillator stall at high or low level after 6 to 18.5 us
// - each check window ends by 20 ms, overall timeout by 1 s
// - reset held at least 2 osc periods; startup takes 192-196 osc cycles
// - wait wakeup resumes operation within 14 system clock cycles
// - power-on or low-voltage reset release starts oscillator and quality check
// - quality check timeout without oscillation switches to self-clock
// - power-on reset sets the flag; clear flag means SRAM intact
// - valid external reset with prior stable oscillation skips the quality check
// - external interrupt leaves stop mode through a full quality check
// - oscillator keeps running in pseudo stop and doze
// - any interrupt or wakeup event ends pseudo stop or doze
// - after recovery fetch interrupt vector if interrupt woke, else continue
// - self-clock mode uses the voltage controlled oscillator as system clock
`timescale 1ns/10ps
`default_nettype none
`include "clock_reset_consts.svh"
module clock_reset_startup_monitor #(
   parameter int unsigned CHECK_WINDOW_CYCLES = `CHECK_WINDOW_CYCLES,
   parameter int unsigned TIMEOUT_CYCLES      = `TIMEOUT_CYCLES
) (
   input  wire logic                                          core_clk_i,
   input  wire logic                                          resetn_i,
   input  wire logic                                          power_on_reset_i,
   input  wire logic                                          low_voltage_reset_i,
   input  wire logic                                          ext_resetn_i,
   input  wire logic                                          osc_level_i,
   input  wire logic                                          mode_req_valid_i,
   input  wire clock_reset_pkg::low_power_mode_type           mode_req_i,
   input  wire logic                                          wait_req_i,
   input  wire clock_reset_pkg::wakeup_type                   wakeup_i,
   input  wire logic                                          flag_clear_i,
   output logic                                               core_resetn_o,
   output clock_reset_pkg::clock_status_type                  clk_status_o,
   output clock_reset_pkg::clock_reset_flag_register_type     clock_reset_flag_register_o,
   output logic                                               osc_fail_o,
   output logic                                               fetch_irq_vector_o,
   output logic                                               resume_o
);
   typedef enum logic [3:0] {
      ST_HOLD,
      ST_CHECK,
      ST_STARTUP,
      ST_RUN,
      ST_STOP,
      ST_LIGHT_SLEEP,
      ST_WAIT,
      ST_RECOVER
   } seq_state_type;

   localparam logic [31:0] WIN_LIMIT = 32'(CHECK_WINDOW_CYCLES);
   localparam logic [31:0] TMO_LIMIT = 32'(TIMEOUT_CYCLES);

   seq_state_type state_r;
   seq_state_type state_nxt;
   logic [31:0]   win_cnt_r;
   logic [31:0]   tmo_cnt_r;
   logic [15:0]   edge_cnt_r;
   logic [7:0]    osc_cnt_r;
   logic [7:0]    rst_low_cnt_r;
   logic [7:0]    wait_cnt_r;
   logic          woke_by_irq_r;
   logic          osc_enable_r;
   logic          self_clk_r;
   logic          stable_r;
   logic          por_flag_r;
   logic          lvr_flag_r;
   logic          core_resetn_r;
   logic          fetch_r;
   logic          resume_r;
   logic          osc_edge;
   logic          osc_fail;

   // hazard: the monitor only watches while the oscillator is meant to run
   crystal_monitor u_xmon (
      .core_clk_i  (core_clk_i),
      .resetn_i    (resetn_i),
      .enable_i    (osc_enable_r),
      .osc_level_i (osc_level_i),
      .osc_edge_o  (osc_edge),
      .osc_fail_o  (osc_fail)
   );

   // decoded conditions
   wire supply_reset  = power_on_reset_i || low_voltage_reset_i;
   // one oscillator period per rising level; a third rise proves two full periods low
   wire osc_rise      = osc_edge && osc_level_i;
   wire ext_rst_valid = !ext_resetn_i && (rst_low_cnt_r >= `MIN_RESET_PULSE_OSC) && osc_rise;
   wire any_wake      = wakeup_i.ext_irq || wakeup_i.int_irq || wakeup_i.other_event;
   wire irq_wake      = wakeup_i.ext_irq || wakeup_i.int_irq;
   wire win_done      = (win_cnt_r >= WIN_LIMIT - 32'd1);
   wire check_pass    = (edge_cnt_r >= `CHECK_EDGES) && !osc_fail;
   wire check_timeout = (tmo_cnt_r >= TMO_LIMIT - 32'd1);
   wire startup_done  = osc_rise && (osc_cnt_r >= `STARTUP_OSC_CYCLES - 8'd1);
   wire wait_done     = (wait_cnt_r >= `WAIT_RECOVERY_CYC - 8'd1);
   wire in_check      = (state_r == ST_CHECK);

   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_HOLD:        state_nxt = supply_reset ? ST_HOLD : ST_CHECK;
         // core still out of reset means a stop wakeup: recover, do not restart
         ST_CHECK: begin
            if (check_pass) begin
               state_nxt = core_resetn_r ? ST_RECOVER : ST_STARTUP;
            end else if (check_timeout) begin
               state_nxt = core_resetn_r ? ST_RECOVER : ST_STARTUP;
            end
         end
         ST_STARTUP:     state_nxt = (startup_done || self_clk_r) ? ST_RUN : ST_STARTUP;
         ST_RUN: begin
            if (wait_req_i) begin
               state_nxt = ST_WAIT;
            end else if (mode_req_valid_i && mode_req_i == clock_reset_pkg::MODE_STOP) begin
               state_nxt = ST_STOP;
            end else if (mode_req_valid_i && mode_req_i != clock_reset_pkg::MODE_RUN) begin
               state_nxt = ST_LIGHT_SLEEP;
            end
         end
         ST_STOP:        state_nxt = wakeup_i.ext_irq ? ST_CHECK : ST_STOP;
         ST_LIGHT_SLEEP: state_nxt = any_wake ? ST_RECOVER : ST_LIGHT_SLEEP;
         ST_WAIT:        state_nxt = any_wake ? ST_RECOVER : ST_WAIT;
         ST_RECOVER:     state_nxt = wait_done ? ST_RUN : ST_RECOVER;
      endcase
      // valid external reset: bypass the check when oscillation was stable
      if (ext_rst_valid) begin
         state_nxt = stable_r ? ST_STARTUP : ST_CHECK;
      end
      if (supply_reset) begin
         state_nxt = ST_HOLD;
      end
   end

   // sequencer state and counters
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r       <= ST_HOLD;
         win_cnt_r     <= 32'h0000_0000;
         tmo_cnt_r     <= 32'h0000_0000;
         edge_cnt_r    <= 16'h0000;
         osc_cnt_r     <= 8'h00;
         rst_low_cnt_r <= 8'h00;
         wait_cnt_r    <= 8'h00;
         woke_by_irq_r <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         // a fresh window restarts the edge count; timeout runs across windows
         win_cnt_r     <= (!in_check || win_done) ? 32'h0000_0000 : win_cnt_r + 32'd1;
         tmo_cnt_r     <= in_check ? tmo_cnt_r + 32'd1 : 32'h0000_0000;
         edge_cnt_r    <= (!in_check || win_done || osc_fail) ? 16'h0000 :
                          (osc_edge && !check_pass) ? edge_cnt_r + 16'h0001 : edge_cnt_r;
         // startup counts oscillator periods from the release of the pin
         osc_cnt_r     <= (state_r != ST_STARTUP || !ext_resetn_i) ? 8'h00 :
                          osc_rise ? osc_cnt_r + 8'h01 : osc_cnt_r;
         // reset pulse width counted in oscillator periods
         rst_low_cnt_r <= ext_resetn_i ? 8'h00 :
                          (osc_rise && rst_low_cnt_r != 8'hff) ? rst_low_cnt_r + 8'h01 :
                          rst_low_cnt_r;
         wait_cnt_r    <= (state_r == ST_RECOVER) ? wait_cnt_r + 8'h01 : 8'h00;
         if (state_r != ST_RECOVER && !in_check) begin // held through a stop check
            woke_by_irq_r <= irq_wake;
         end
      end
   end

   // oscillator, self-clock and flag state
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         osc_enable_r  <= 1'b0;
         self_clk_r    <= 1'b0;
         stable_r      <= 1'b0;
         por_flag_r    <= 1'b1;
         lvr_flag_r    <= 1'b0;
         core_resetn_r <= 1'b0;
         fetch_r       <= 1'b0;
         resume_r      <= 1'b0;
      end else begin
         // supply reset hold and stop mode halt the crystal; sleep states keep it running
         osc_enable_r  <= (state_nxt != ST_HOLD) && (state_nxt != ST_STOP);
         // a supply reset restarts the crystal, so the self clock is dropped
         if (supply_reset) begin
            self_clk_r <= 1'b0;
         end else if (in_check && check_timeout && !check_pass) begin
            self_clk_r <= 1'b1;
         end else if (in_check && check_pass) begin
            self_clk_r <= 1'b0;
         end else if (osc_fail && state_r == ST_RUN) begin
            self_clk_r <= 1'b1;
         end
         // kept across external reset, lost on supply reset, stop, or failure
         if (supply_reset || osc_fail || state_r == ST_STOP) begin
            stable_r <= 1'b0;
         end else if (in_check && check_pass) begin
            stable_r <= 1'b1;
         end
         // set wins over software clear
         if (power_on_reset_i) begin
            por_flag_r <= 1'b1;
         end else if (flag_clear_i) begin
            por_flag_r <= 1'b0;
         end
         if (low_voltage_reset_i) begin
            lvr_flag_r <= 1'b1;
         end else if (flag_clear_i) begin
            lvr_flag_r <= 1'b0;
         end
         core_resetn_r <= (state_nxt == ST_RUN) || (core_resetn_r &&
                          state_nxt != ST_HOLD && !ext_rst_valid &&
                          state_nxt != ST_STARTUP);
         fetch_r       <= (state_r == ST_RECOVER) && wait_done && woke_by_irq_r;
         resume_r      <= (state_r == ST_RECOVER) && wait_done;
      end
   end

   // status outputs
   assign core_resetn_o                                   = core_resetn_r;
   assign clk_status_o.osc_enable                         = osc_enable_r;
   assign clk_status_o.sys_clk_enable                     = core_resetn_r &&
                                                            (state_r == ST_RUN ||
                                                             state_r == ST_RECOVER);
   assign clk_status_o.self_clock_mode                    = self_clk_r;
   assign clk_status_o.use_vco_source                     = self_clk_r;
   assign clock_reset_flag_register_o.power_on_reset_flag    = por_flag_r;
   assign clock_reset_flag_register_o.low_voltage_reset_flag = lvr_flag_r;
   assign clock_reset_flag_register_o.stable_osc_seen        = stable_r;
   assign clock_reset_flag_register_o.self_clock_active      = self_clk_r;
   assign osc_fail_o                                      = osc_fail;
   assign fetch_irq_vector_o                              = fetch_r;
   assign resume_o                                        = resume_r;

   // assertions
   property p_wait_recovery;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (state_r == ST_WAIT && any_wake && !supply_reset && !ext_rst_valid)
         |-> ##[1:15] resume_r;
   endproperty
   a_wait_recovery: assert property (p_wait_recovery)
      else $error("wait recovery exceeded 14 cycles");

   property p_supply_release_check;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (state_r == ST_HOLD && !supply_reset) |=> state_r == ST_CHECK;
   endproperty
   a_supply_release_check: assert property (p_supply_release_check)
      else $error("supply reset release did not start the quality check");

   property p_timeout_self_clock;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (in_check && check_timeout && !check_pass && !supply_reset) |=> self_clk_r;
   endproperty
   a_timeout_self_clock: assert property (p_timeout_self_clock)
      else $error("timeout did not select the self clock");

   property p_por_flag;
      @(posedge core_clk_i) disable iff (!resetn_i)
      power_on_reset_i |=> por_flag_r;
   endproperty
   a_por_flag: assert property (p_por_flag)
      else $error("power-on reset flag not set");

   property p_ext_reset_bypass;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (ext_rst_valid && stable_r && !supply_reset) |=> state_r == ST_STARTUP && stable_r;
   endproperty
   a_ext_reset_bypass: assert property (p_ext_reset_bypass)
      else $error("external reset with stable oscillator did not bypass the check");

   property p_stop_wake_check;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (state_r == ST_STOP && wakeup_i.ext_irq && !supply_reset && !ext_rst_valid)
         |=> in_check && !clk_status_o.sys_clk_enable;
   endproperty
   a_stop_wake_check: assert property (p_stop_wake_check)
      else $error("stop wakeup released clocks without a quality check");

   property p_osc_runs_in_sleep;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (state_r == ST_LIGHT_SLEEP) |-> osc_enable_r;
   endproperty
   a_osc_runs_in_sleep: assert property (p_osc_runs_in_sleep)
      else $error("oscillator stopped in pseudo stop or doze");

   property p_sleep_wake;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (state_r == ST_LIGHT_SLEEP && any_wake && !supply_reset && !ext_rst_valid)
         |=> state_r == ST_RECOVER;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake)
      else $error("wakeup event did not end pseudo stop or doze");

   property p_fetch_only_irq;
      @(posedge core_clk_i) disable iff (!resetn_i)
      fetch_r |-> resume_r && woke_by_irq_r;
   endproperty
   a_fetch_only_irq: assert property (p_fetch_only_irq)
      else $error("interrupt vector fetched without an interrupt wakeup");

   property p_vco_source;
      @(posedge core_clk_i) disable iff (!resetn_i)
      self_clk_r |-> clk_status_o.use_vco_source;
   endproperty
   a_vco_source: assert property (p_vco_source)
      else $error("self clock mode not sourced from the oscillator of the pll");

   c_reach_run:     cover property (@(posedge core_clk_i) disable iff (!resetn_i)
                                    state_r == ST_RUN);
   c_self_clock:    cover property (@(posedge core_clk_i) disable iff (!resetn_i)
                                    $rose(self_clk_r));
   c_irq_fetch:     cover property (@(posedge core_clk_i) disable iff (!resetn_i)
                                    fetch_r);
   c_ext_bypass:    cover property (@(posedge core_clk_i) disable iff (!resetn_i)
                                    ext_rst_valid && stable_r);
endmodule
`default_nettype wire

// ### dv/osc_model.sv
// behavioural crystal oscillator as seen through its sampled level
`timescale 1ns/10ps
`default_nettype none
module osc_model (
   input  wire logic core_clk_i,
   input  wire logic resetn_i,
   input  wire logic osc_enable_i,
   input  wire logic run_i,
   input  wire logic stop_level_i,
   output logic      osc_level_o
);
   logic div_r;

   // one level change every second core cycle, so the sampler never misses an edge
   // a dead or disabled crystal parks at a fixed level, as a real stalled one does
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_r       <= 1'b0;
         osc_level_o <= 1'b0;
      end else if (osc_enable_i && run_i) begin
         div_r <= ~div_r;
         if (div_r) begin
            osc_level_o <= ~osc_level_o;
         end
      end else begin
         osc_level_o <= stop_level_i;
      end
   end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the clock/reset startup monitor
`timescale 1ns/10ps
`default_nettype none
`include "clock_reset_consts.svh"
module tb_top;
   localparam int CW  = 10000; // shortened check window
   localparam int TOC = 40000; // shortened overall timeout
   logic                                           core_clk;
   logic                                           resetn;
   logic                                           por;
   logic                                           low_voltage_reset;
   logic                                           ext_rstn;
   logic                                           osc_level;
   logic                                           mode_valid;
   clock_reset_pkg::low_power_mode_type            mode;
   logic                                           wait_req;
   clock_reset_pkg::wakeup_type                    wake;
   logic                                           flag_clear;
   logic                                           core_resetn;
   clock_reset_pkg::clock_status_type              st;
   clock_reset_pkg::clock_reset_flag_register_type fl;
   logic                                           osc_fail;
   logic                                           fetch;
   logic                                           resume;
   logic                                           osc_run;
   logic                                           osc_stop_lv;
   logic [2:0]                                     w;
   int                                             err_count;
   int                                             n_tests;
   int                                             n;
   int                                             n2;
   int                                             cyc;

   clock_reset_startup_monitor #(.CHECK_WINDOW_CYCLES(CW), .TIMEOUT_CYCLES(TOC)) dut_u (
      .core_clk_i(core_clk), .resetn_i(resetn), .power_on_reset_i(por),
      .low_voltage_reset_i(low_voltage_reset), .ext_resetn_i(ext_rstn), .osc_level_i(osc_level),
      .mode_req_valid_i(mode_valid), .mode_req_i(mode), .wait_req_i(wait_req),
      .wakeup_i(wake), .flag_clear_i(flag_clear), .core_resetn_o(core_resetn),
      .clk_status_o(st), .clock_reset_flag_register_o(fl), .osc_fail_o(osc_fail),
      .fetch_irq_vector_o(fetch), .resume_o(resume));

   osc_model osc_u (
      .core_clk_i(core_clk), .resetn_i(resetn), .osc_enable_i(st.osc_enable),
      .run_i(osc_run), .stop_level_i(osc_stop_lv), .osc_level_o(osc_level));

   // 250 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic check_bit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic check_cnt(input string nm, input int lo, input int hi, input int g);
      n_tests++;
      if (g < lo || g > hi) begin
         err_count++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   function automatic logic sel(input int k);
      case (k)
         0: sel = core_resetn;
         1: sel = resume;
         default: sel = osc_fail;
      endcase
   endfunction

   // bounded wait on one output, sampled after the edge has settled
   task automatic wait_on(input int k, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge core_clk);
         #1;
         cnt++;
      end while (sel(k) !== 1'b1 && cnt < lim);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // hang guard, well above the expected run of about 60000 cycles
   initial begin
      cyc = 0;
      forever begin
         @(posedge core_clk);
         cyc++;
         if (cyc >= 90000) begin
            err_count++;
            $display("CHECK FAILED run length expected below 90000 seen %0d", cyc);
            final_report();
         end
      end
   end

   initial begin
      {resetn, por, low_voltage_reset, mode_valid, wait_req, flag_clear, osc_stop_lv} = '0;
      {ext_rstn, osc_run} = 2'b11;
      mode = clock_reset_pkg::MODE_RUN;
      wake = '0;
      err_count = 0;
      n_tests = 0;
      void'($urandom(76));
      repeat (4) @(posedge core_clk);
      #1 check_bit("core reset in reset", 1'b0, core_resetn);
      check_bit("power-on flag in reset", 1'b1, fl.power_on_reset_flag);
      // power-on release: oscillator and quality check start only after it
      @(posedge core_clk);
      resetn <= 1'b1;
      por <= 1'b1;
      repeat (6) @(posedge core_clk);
      #1 check_bit("osc held off", 1'b0, st.osc_enable);
      @(posedge core_clk);
      por <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 check_bit("osc started", 1'b1, st.osc_enable);
      wait_on(0, 2 * CW + 1000, n);
      check_cnt("power-on to core run", 2 * 4096 - 64, CW + 1000, n);
      check_bit("power-on flag", 1'b1, fl.power_on_reset_flag);
      check_bit("stable osc seen", 1'b1, fl.stable_osc_seen);
      check_bit("no self clock", 1'b0, st.self_clock_mode);
      @(posedge core_clk);
      flag_clear <= 1'b1;
      @(posedge core_clk);
      flag_clear <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 check_bit("flag cleared", 1'b0, fl.power_on_reset_flag);
      $display("test power_on done");
      // external reset longer than two osc periods with a stable osc
      @(posedge core_clk);
      ext_rstn <= 1'b0;
      n2 = 16 + $urandom_range(8);
      repeat (n2) @(posedge core_clk);
      ext_rstn <= 1'b1;
      #1 check_bit("core reset from pin", 1'b0, core_resetn);
      wait_on(0, CW, n);
      check_cnt("pin reset to run", 4 * 192 - 8, 4 * 196 + 8, n);
      check_bit("stable survives pin reset", 1'b1, fl.stable_osc_seen);
      check_bit("no power-on flag", 1'b0, fl.power_on_reset_flag);
      $display("test ext_reset done");
      // wait, pseudo stop and doze entered and left by every wakeup source
      for (int i = 0; i < 9; i++) begin
         w = 3'b100 >> (i % 3);
         @(posedge core_clk);
         if (i < 3) begin
            wait_req <= 1'b1;
         end else begin
            mode_valid <= 1'b1;
            mode <= (i < 6) ? clock_reset_pkg::MODE_PSEUDO_STOP : clock_reset_pkg::MODE_DOZE;
         end
         @(posedge core_clk);
         wait_req <= 1'b0;
         mode_valid <= 1'b0;
         repeat (1 + $urandom_range(5)) @(posedge core_clk);
         #1 check_bit("osc kept running", 1'b1, st.osc_enable);
         @(posedge core_clk);
         wake <= clock_reset_pkg::wakeup_type'(w);
         wait_on(1, 40, n);
         check_cnt("wake to resume", 2, `WAIT_RECOVERY_CYC + 3, n);
         check_bit("vector fetch", w != 3'b001, fetch);
         @(posedge core_clk);
         wake <= '0;
      end
      $display("test wait_doze done");
      // stop: only the external interrupt wakes, through a full check
      @(posedge core_clk);
      mode_valid <= 1'b1;
      mode <= clock_reset_pkg::MODE_STOP;
      @(posedge core_clk);
      mode_valid <= 1'b0;
      repeat (20) @(posedge core_clk);
      #1 check_bit("osc stopped in stop", 1'b0, st.osc_enable);
      @(posedge core_clk);
      wake <= 3'b011;
      n = 0;
      repeat (60) begin
         @(posedge core_clk);
         #1 n += (resume === 1'b1);
      end
      check_cnt("refused stop wake", 0, 0, n);
      @(posedge core_clk);
      wake <= 3'b100;
      wait_on(1, 2 * CW + 1000, n);
      check_cnt("stop recovery time", 2 * 4096 - 64, CW + 1000, n);
      check_bit("stop vector fetch", 1'b1, fetch);
      @(posedge core_clk);
      wake <= '0;
      $display("test stop done");
      // crystal stalls low while running
      @(posedge core_clk);
      osc_run <= 1'b0;
      wait_on(2, 6000, n);
      check_cnt("stall low to fail", `XMON_CYCLES - 4, `XMON_MAX_CYCLES, n);
      repeat (4) @(posedge core_clk);
      #1 check_bit("self clock after fail", 1'b1, st.self_clock_mode);
      check_bit("vco source", 1'b1, st.use_vco_source);
      @(posedge core_clk);
      osc_run <= 1'b1;
      repeat (8) @(posedge core_clk);
      #1 check_bit("fail clears on edges", 1'b0, osc_fail);
      $display("test stall_low done");
      // low-voltage reset with a crystal stuck high: timeout to self clock
      @(posedge core_clk);
      osc_stop_lv <= 1'b1;
      osc_run <= 1'b0;
      low_voltage_reset <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1 check_bit("core reset in low voltage", 1'b0, core_resetn);
      @(posedge core_clk);
      low_voltage_reset <= 1'b0;
      wait_on(2, 6000, n);
      check_cnt("stall high to fail", `XMON_CYCLES - 16, `XMON_MAX_CYCLES + 8, n);
      wait_on(0, TOC + CW, n2);
      check_cnt("timeout to run", TOC - 8, TOC + 800, n + n2);
      check_bit("self clock on timeout", 1'b1, st.self_clock_mode);
      check_bit("self clock flag", 1'b1, fl.self_clock_active);
      check_bit("vco after timeout", 1'b1, st.use_vco_source);
      check_bit("low voltage flag", 1'b1, fl.low_voltage_reset_flag);
      check_bit("no stable osc", 1'b0, fl.stable_osc_seen);
      $display("test timeout done");
      final_report();
   end
endmodule
`default_nettype wire
